/* File: src/rtc_irq_params.svh */
// offsets, field positions, reset values and timing counts of the irq block
// assumes an 8-bit register port addressed at the printed byte offsets
`ifndef RTC_IRQ_PARAMS_SVH
`define RTC_IRQ_PARAMS_SVH
`define RTC_FLAGS_ADDR   21'h1FFFF0
`define RTC_CTRL_ADDR    21'h1FFFF6
// event_flags fields
`define FLG_WD           7
`define FLG_AL           6
`define FLG_PF           5
`define FLG_OSC          4
`define FLG_BKF          3
`define FLG_CAL          2
`define FLG_UNLOCK       1
// interrupt_control fields
`define CTL_WD_EN        7
`define CTL_AL_EN        6
`define CTL_PF_EN        5
`define CTL_SQW_EN       4
`define CTL_ACT_HIGH     3
`define CTL_PULSE        2
`define CTL_SEL_HI       1
`define CTL_SEL_LO       0
`define RTC_CTRL_RST     8'h08
`define RTC_FLAGS_RST    8'h00
// prescaler taps: bit k toggles at 32768 / 2**k Hz
`define TAP_1HZ          15
`define TAP_512HZ        6
`define TAP_4096HZ       3
`define TAP_32KHZ        0
// timing
`define RTC_CLK_HZ       200000000
`define RTC_OSC_HZ       32768
`define RTC_HALF_TICK    (`RTC_CLK_HZ / (2 * `RTC_OSC_HZ))
`define RTC_PULSE_MS     200
`define RTC_PULSE_TICKS  ((`RTC_PULSE_MS * 2 * `RTC_OSC_HZ) / 1000)
`endif

/* File: src/rtc_irq_pkg.sv */
// pin source type used inside the irq block; the bench does not use it
// assumes nothing beyond a SystemVerilog tool
package rtc_irq_pkg;
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_CAL  = 2'b01,
        SRC_SQW  = 2'b10,
        SRC_IRQ  = 2'b11
    } pin_src_t;
endpackage

/* File: src/rtc_irq_out.sv */
// interrupt, flag and pin-output logic of a backed-up real-time clock
// assumes event inputs are one-cycle pulses synchronous to clock
`timescale 1ns/10ps
`default_nettype none
`include "rtc_irq_params.svh"

// Overview of operation
// - main supply loss starts a store pulse and moves oscillator to backup.
// - on backup, register reads and writes are blocked; timekeeping continues.
// - backup voltage low sets backup_fail_flag, even while on backup.
// - watchdog, alarm, power fail each own an enable bit and a flag.
// - interrupt only when a flag rises with its enable bit set.
// - pulse mode drives the pin active for about 200 ms.
// - level mode holds the pin active until flags or control are read.
// - no interrupts while running from backup power.
// - interrupts only after recall completes; host ignores pin during holdoff.
// - cleared enable leaves an event affecting only its flag.
// - square_wave_en puts a square wave on the pin over all interrupts.
// - square_freq_sel picks 1 Hz, 512 Hz, 4096 Hz or 32768 Hz.
// - active high means push-pull; active low means open drain.
// - calibration_out puts 512 Hz on the pin ahead of the square wave.
// - calibration_out clears at every power-up.
// - flags read clears the watchdog, alarm and power fail flags and releases the pin, cutting pulses short.
// - pin priority: calibration, square wave, interrupts, else high impedance.
// - timeout, alarm match and power fail set their flags.
// - power-up loads all flags with zero; osc_stopped then sets osc_fail_flag.
// - square wave suppressed while on backup power.
// - calibration clock toggles at nominal 512 Hz.
module rtc_irq_out #(
    parameter int ADDR_W   = 21,
    parameter int PULSE_W  = 16,
    parameter int HALF_W   = 12,
    parameter logic [PULSE_W-1:0] PULSE_TICKS = PULSE_W'(`RTC_PULSE_TICKS),
    parameter logic [HALF_W-1:0]  HALF_TICK   = HALF_W'(`RTC_HALF_TICK)
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // supply and status
    input  wire logic              vcc_ok,
    input  wire logic              backup_low,
    input  wire logic              recall_done,
    input  wire logic              osc_stopped,
    // event sources
    input  wire logic              watchdog_timeout,
    input  wire logic              alarm_match,
    input  wire logic              power_fail,
    // power control
    output logic                   store_start,
    output logic                   osc_on_backup,
    output logic                   host_blocked,
    // interrupt pin
    output logic                   irq_out,
    output logic                   irq_oe_n
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [7:0]         ctrl_q;
    logic               wd_flag_q;
    logic               al_flag_q;
    logic               pf_flag_q;
    logic               osc_fail_q;
    logic               bk_fail_q;
    logic               cal_q;
    logic               unlock_q;
    logic [7:0]         rdata_q;
    logic               vcc_prev_q;
    logic               store_q;
    logic               backup_q;
    logic               blocked_q;
    logic               irq_hold_q;
    logic [PULSE_W-1:0] pulse_cnt_q;
    logic [HALF_W-1:0]  half_cnt_q;
    logic [15:0]        presc_q;
    logic               out_q;
    logic               oe_n_q;
    rtc_irq_pkg::pin_src_t src_q;

    logic               flags_hit;
    logic               ctrl_hit;
    logic               flags_rd;
    logic               host_rd;
    logic               flags_wr;
    logic               ctrl_wr;
    logic               irq_req;
    logic               irq_assert;
    logic               tick;
    logic [7:0]         flags_v;
    logic               wave;
    logic               lvl;
    logic               out_d;
    logic               oe_n_d;
    rtc_irq_pkg::pin_src_t src_d;

    // ----------------------------------------
    // access decode
    // ----------------------------------------
    assign flags_hit = (reg_addr == ADDR_W'(`RTC_FLAGS_ADDR));
    assign ctrl_hit  = (reg_addr == ADDR_W'(`RTC_CTRL_ADDR));
    // host sees nothing of the block while on backup
    assign flags_rd  = reg_rd && vcc_ok && flags_hit;
    assign host_rd   = reg_rd && vcc_ok && (flags_hit || ctrl_hit);
    assign flags_wr  = reg_wr && vcc_ok && flags_hit;
    assign ctrl_wr   = reg_wr && vcc_ok && ctrl_hit;

    assign flags_v = {wd_flag_q, al_flag_q, pf_flag_q, osc_fail_q,
                      bk_fail_q, cal_q, unlock_q, 1'b0};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (host_rd) begin
            rdata_q <= flags_hit ? flags_v : ctrl_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q <= `RTC_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_q <= reg_wdata;
        end
    end

    // ----------------------------------------
    // event flags
    // ----------------------------------------
    // a set in the same cycle as the clearing read wins, so no event is lost
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wd_flag_q <= 1'b0;
            al_flag_q <= 1'b0;
            pf_flag_q <= 1'b0;
        end else begin
            wd_flag_q <= watchdog_timeout | (wd_flag_q & ~flags_rd);
            al_flag_q <= alarm_match | (al_flag_q & ~flags_rd);
            pf_flag_q <= power_fail | (pf_flag_q & ~flags_rd);
        end
    end

    // writable status bits need the unlock bit set on an earlier write
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            unlock_q   <= 1'b0;
            cal_q      <= 1'b0;
            osc_fail_q <= 1'b0;
            bk_fail_q  <= 1'b0;
        end else begin
            if (flags_wr) begin
                unlock_q <= reg_wdata[`FLG_UNLOCK];
            end
            if (flags_wr && unlock_q) begin
                cal_q <= reg_wdata[`FLG_CAL];
            end
            if (osc_stopped) begin
                osc_fail_q <= 1'b1;
            end else if (flags_wr && unlock_q) begin
                osc_fail_q <= reg_wdata[`FLG_OSC];
            end
            // monitored on backup too, so the flag is there at power-up
            if (backup_low) begin
                bk_fail_q <= 1'b1;
            end else if (flags_wr && unlock_q) begin
                bk_fail_q <= reg_wdata[`FLG_BKF];
            end
        end
    end

    // ----------------------------------------
    // power switch-over
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            vcc_prev_q <= 1'b1;
            store_q    <= 1'b0;
            backup_q   <= 1'b0;
            blocked_q  <= 1'b0;
        end else begin
            vcc_prev_q <= vcc_ok;
            store_q    <= vcc_prev_q & ~vcc_ok;
            backup_q   <= ~vcc_ok;
            blocked_q  <= ~vcc_ok;
        end
    end

    // ----------------------------------------
    // oscillator prescaler
    // ----------------------------------------
    // one tick per half period of the 32.768 kHz oscillator
    assign tick = (half_cnt_q == HALF_W'(0));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            half_cnt_q <= HALF_TICK - HALF_W'(1);
            presc_q    <= 16'h0000;
        end else begin
            half_cnt_q <= tick ? HALF_TICK - HALF_W'(1) : half_cnt_q - HALF_W'(1);
            if (tick) begin
                presc_q <= presc_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // interrupt request and hold
    // ----------------------------------------
    assign irq_req = ((watchdog_timeout & ctrl_q[`CTL_WD_EN])
                    | (alarm_match & ctrl_q[`CTL_AL_EN])
                    | (power_fail & ctrl_q[`CTL_PF_EN]))
                   & vcc_ok
                   & recall_done;

    assign irq_assert = irq_hold_q | (pulse_cnt_q != PULSE_W'(0));

    // level mode: held until flags or control read
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_hold_q <= 1'b0;
        end else begin
            irq_hold_q <= (irq_req & ~ctrl_q[`CTL_PULSE])
                        | (irq_hold_q & ~host_rd);
        end
    end

    // pulse mode: counted in oscillator ticks, cut short by a flags read
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pulse_cnt_q <= PULSE_W'(0);
        end else if (irq_req && ctrl_q[`CTL_PULSE]) begin
            pulse_cnt_q <= PULSE_TICKS;
        end else if (flags_rd) begin
            pulse_cnt_q <= PULSE_W'(0);
        end else if (tick && pulse_cnt_q != PULSE_W'(0)) begin
            pulse_cnt_q <= pulse_cnt_q - PULSE_W'(1);
        end
    end

    // ----------------------------------------
    // pin source and driver
    // ----------------------------------------
    always_comb begin
        src_d = rtc_irq_pkg::SRC_NONE;
        wave  = 1'b0;
        if (!vcc_ok) begin
            src_d = rtc_irq_pkg::SRC_NONE;
        end else if (cal_q) begin
            src_d = rtc_irq_pkg::SRC_CAL;
        end else if (ctrl_q[`CTL_SQW_EN]) begin
            src_d = rtc_irq_pkg::SRC_SQW;
        end else if (|ctrl_q[`CTL_WD_EN:`CTL_PF_EN]) begin
            src_d = rtc_irq_pkg::SRC_IRQ;
        end
        case ({ctrl_q[`CTL_SEL_HI], ctrl_q[`CTL_SEL_LO]})
            2'b00:   wave = presc_q[`TAP_1HZ];
            2'b01:   wave = presc_q[`TAP_512HZ];
            2'b10:   wave = presc_q[`TAP_4096HZ];
            2'b11:   wave = presc_q[`TAP_32KHZ];
            default: wave = 1'b0;
        endcase
    end

    // lvl is the wanted pin level; open drain can only pull it low
    always_comb begin
        lvl    = 1'b1;
        out_d  = 1'b0;
        oe_n_d = 1'b1;
        case (src_d)
            rtc_irq_pkg::SRC_CAL: lvl = presc_q[`TAP_512HZ];
            rtc_irq_pkg::SRC_SQW: lvl = wave;
            rtc_irq_pkg::SRC_IRQ: lvl = ctrl_q[`CTL_ACT_HIGH] ? irq_assert : ~irq_assert;
            default:              lvl = 1'b1;
        endcase
        if (src_d != rtc_irq_pkg::SRC_NONE) begin
            if (ctrl_q[`CTL_ACT_HIGH]) begin
                out_d  = lvl;
                oe_n_d = 1'b0;
            end else begin
                out_d  = 1'b0;
                oe_n_d = lvl;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            src_q  <= rtc_irq_pkg::SRC_NONE;
            out_q  <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            src_q  <= src_d;
            out_q  <= out_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign reg_rdata     = rdata_q;
    assign store_start   = store_q;
    assign osc_on_backup = backup_q;
    assign host_blocked  = blocked_q;
    assign irq_out       = out_q;
    assign irq_oe_n      = oe_n_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_STORE_PULSE: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(vcc_ok) |=> store_q ##1 !store_q)
        else $error("store pulse missing on supply loss");

    AST_BACKUP_NO_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
        (!vcc_ok && reg_wr) |=> $stable(ctrl_q))
        else $error("register written on backup");

    AST_BACKUP_FAIL: assert property (@(posedge clock) disable iff (sys_rst)
        backup_low |=> bk_fail_q)
        else $error("backup fail flag not set");

    AST_DISABLED_SOURCE: assert property (@(posedge clock) disable iff (sys_rst)
        (alarm_match && !ctrl_q[`CTL_AL_EN] && !watchdog_timeout && !power_fail
         && !irq_assert) |=> (!irq_assert && al_flag_q))
        else $error("disabled source touched the pin");

    AST_PULSE_LOAD: assert property (@(posedge clock) disable iff (sys_rst)
        (irq_req && ctrl_q[`CTL_PULSE]) |=> (pulse_cnt_q == PULSE_TICKS && !irq_hold_q))
        else $error("pulse not loaded with full width");

    AST_NO_IRQ_BACKUP: assert property (@(posedge clock) disable iff (sys_rst)
        !vcc_ok |=> (oe_n_q && src_q == rtc_irq_pkg::SRC_NONE))
        else $error("pin driven on backup");

    AST_HOLDOFF: assert property (@(posedge clock) disable iff (sys_rst)
        (!recall_done && !irq_assert) |=> !irq_assert)
        else $error("interrupt before recall done");

    AST_CAL_FIRST: assert property (@(posedge clock) disable iff (sys_rst)
        (cal_q && vcc_ok) |=> (src_q == rtc_irq_pkg::SRC_CAL))
        else $error("calibration clock not selected");

    AST_SQW_OVER_IRQ: assert property (@(posedge clock) disable iff (sys_rst)
        (!cal_q && vcc_ok && ctrl_q[`CTL_SQW_EN]) |=> (src_q == rtc_irq_pkg::SRC_SQW))
        else $error("square wave not selected");

    AST_READ_CLEARS: assert property (@(posedge clock) disable iff (sys_rst)
        (flags_rd && !watchdog_timeout && !alarm_match && !power_fail)
        |=> (!wd_flag_q && !al_flag_q && !pf_flag_q && pulse_cnt_q == PULSE_W'(0)))
        else $error("flags read did not clear");

    AST_SET_WINS: assert property (@(posedge clock) disable iff (sys_rst)
        (flags_rd && alarm_match) |=> al_flag_q)
        else $error("event lost against clearing read");

    AST_LEVEL_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
        (irq_hold_q && !host_rd) |=> irq_hold_q)
        else $error("level interrupt dropped without read");

endmodule
`default_nettype wire

/* File: dv/rtc_host_model.sv */
// host-side partner: resolves the interrupt pin and counts its transitions
// assumes a board pull-up on the pin and the same clock as the irq block
`timescale 1ns/10ps
`default_nettype none

module rtc_host_model (
    // clock
    input  wire logic        clock,
    // pin from the block
    input  wire logic        irq_out,
    input  wire logic        irq_oe_n,
    // host control
    input  wire logic        cnt_clr,
    input  wire logic        ignore,
    // what the host sees
    output logic             pin_level,
    output logic [15:0]      toggles
);
    // ----------------------------------------
    // pin resolution and edge counting
    // ----------------------------------------
    logic last_q;

    // pull-up takes the pin whenever the block lets go
    assign pin_level = irq_oe_n ? 1'h1 : irq_out;

    // edges inside the recall holdoff are not trusted, so not counted
    always_ff @(posedge clock) begin
        last_q <= pin_level;
        if (cnt_clr) begin
            toggles <= 16'h0000;
        end else if (!ignore && (pin_level != last_q)) begin
            toggles <= toggles + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: dv/rtc_interrupt_output_logic_bench.sv */
// self-checking bench for the irq, flag and pin logic, driven over the register port
// assumes the host model is compiled first and the params header is on the include path
`timescale 1ns/10ps
`default_nettype none
`include "rtc_irq_params.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD %s expected %0h seen %0h", nm, exp, got); end end

module rtc_interrupt_output_logic_bench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clock;
    logic        sys_rst;
    logic [20:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        vcc_ok;
    logic        backup_low;
    logic        recall_done;
    logic        osc_stopped;
    logic [2:0]  ev;
    logic        store_start;
    logic        osc_on_backup;
    logic        host_blocked;
    logic        irq_out;
    logic        irq_oe_n;
    logic        pin_level;
    logic        cnt_clr;
    logic [15:0] toggles;
    logic [7:0]  rd_q;
    logic [3:0]  n;
    int          miscompares;
    int          comparisons;
    int          exp_tog [4] = '{0, 16, 128, 1024};

    initial clock = 1'h0;
    always #2.5 clock = ~clock;

    // short counts keep the pulse and square wave runs brief
    rtc_irq_out #(
        .PULSE_TICKS (16'h0004),
        .HALF_TICK   (12'h002)
    ) rtc_irq_out_i (
        .clock            (clock),
        .sys_rst          (sys_rst),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .vcc_ok           (vcc_ok),
        .backup_low       (backup_low),
        .recall_done      (recall_done),
        .osc_stopped      (osc_stopped),
        .watchdog_timeout (ev[2]),
        .alarm_match      (ev[1]),
        .power_fail       (ev[0]),
        .store_start      (store_start),
        .osc_on_backup    (osc_on_backup),
        .host_blocked     (host_blocked),
        .irq_out          (irq_out),
        .irq_oe_n         (irq_oe_n)
    );

    rtc_host_model rtc_host_model_i (
        .clock     (clock),
        .irq_out   (irq_out),
        .irq_oe_n  (irq_oe_n),
        .cnt_clr   (cnt_clr),
        .ignore    (!recall_done),
        .pin_level (pin_level),
        .toggles   (toggles)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask

    // one idle cycle after each strobe keeps a strobe from being driven twice at one edge
    task automatic wr(input logic [20:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clock);
        reg_wr    <= 1'h0;
        @(posedge clock);
    endtask

    task automatic rchk(input logic [20:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clock);
        reg_rd   <= 1'h0;
        #1;
        rd_q = reg_rdata;
        `CHK((a == `RTC_FLAGS_ADDR) ? "event_flags" : "register", e, rd_q)
        @(posedge clock);
    endtask

    task automatic pin(input logic [1:0] e);
        #1;
        `CHK("oe_n_and_out", e, {irq_oe_n, irq_out})
        @(posedge clock);
    endtask

    task automatic tz();
        #1;
        `CHK("pin_oe_n", 1'h1, irq_oe_n)
        @(posedge clock);
    endtask

    task automatic fire(input int i);
        ev[i] <= 1'h1;
        @(posedge clock);
        ev[i] <= 1'h0;
        @(posedge clock);
    endtask

    // toggles in 2048 cycles, one either way for window phase
    task automatic freq(input int e);
        cnt_clr <= 1'h1;
        @(posedge clock);
        cnt_clr <= 1'h0;
        cyc(2048);
        #1;
        `CHK("toggles_in_range", 1'h1, (toggles + 1 >= e) && (toggles <= e + 1))
        @(posedge clock);
    endtask

    task automatic do_reset();
        sys_rst <= 1'h1;
        cyc(3);
        sys_rst <= 1'h0;
        cyc(1);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, backup_low, osc_stopped, ev, cnt_clr} = '0;
        {vcc_ok, recall_done} = 2'h3;
        miscompares = 0;
        comparisons = 0;
        do_reset();
        tz();
        rchk(`RTC_FLAGS_ADDR, 8'h00);
        rchk(`RTC_CTRL_ADDR, 8'h08);
        rchk(21'h1FFFF7, 8'h00);
        wr(`RTC_CTRL_ADDR, 8'hE5);
        rchk(`RTC_CTRL_ADDR, 8'hE5);
        for (int i = 0; i < 3; i++) begin
            wr(`RTC_CTRL_ADDR, 8'(32'h28 | (32'h20 << i)));
            fire(i);
            pin(2'h1);
            cyc(20);
            pin(2'h1);
            rchk(`RTC_FLAGS_ADDR, 8'(32'h20 << i));
            pin(2'h0);
            rchk(`RTC_FLAGS_ADDR, 8'h00);
        end
        wr(`RTC_CTRL_ADDR, 8'h88);
        fire(1);
        pin(2'h0);
        rchk(`RTC_FLAGS_ADDR, 8'h40);
        // alarm in the very cycle of a clearing read must survive it
        ev[1]    <= 1'h1;
        reg_addr <= `RTC_FLAGS_ADDR;
        reg_rd   <= 1'h1;
        @(posedge clock);
        ev[1]    <= 1'h0;
        reg_rd   <= 1'h0;
        @(posedge clock);
        rchk(`RTC_FLAGS_ADDR, 8'h40);
        wr(`RTC_CTRL_ADDR, 8'h40);
        fire(1);
        pin(2'h0);
        rchk(`RTC_FLAGS_ADDR, 8'h40);
        pin(2'h2);
        wr(`RTC_CTRL_ADDR, 8'h48);
        fire(1);
        pin(2'h1);
        rchk(`RTC_CTRL_ADDR, 8'h48);
        pin(2'h0);
        rchk(`RTC_FLAGS_ADDR, 8'h40);
        wr(`RTC_CTRL_ADDR, 8'h4C);
        fire(1);
        pin(2'h1);
        cyc(3);
        pin(2'h1);
        cyc(12);
        pin(2'h0);
        rchk(`RTC_FLAGS_ADDR, 8'h40);
        fire(1);
        pin(2'h1);
        rchk(`RTC_FLAGS_ADDR, 8'h40);
        pin(2'h0);
        wr(`RTC_CTRL_ADDR, 8'h48);
        recall_done <= 1'h0;
        fire(1);
        pin(2'h0);
        rchk(`RTC_FLAGS_ADDR, 8'h40);
        recall_done <= 1'h1;
        // ----------------------------------------
        // backup power
        // ----------------------------------------
        wr(`RTC_CTRL_ADDR, 8'h5B);
        vcc_ok <= 1'h0;
        n = 4'h0;
        repeat (6) begin
            @(posedge clock);
            #1;
            n = n + 4'(store_start);
        end
        `CHK("store_pulses", 4'h1, n)
        `CHK("osc_on_backup", 1'h1, osc_on_backup)
        `CHK("host_blocked", 1'h1, host_blocked)
        `CHK("pin_oe_n", 1'h1, irq_oe_n)
        @(posedge clock);
        fire(1);
        tz();
        backup_low <= 1'h1;
        @(posedge clock);
        backup_low <= 1'h0;
        wr(`RTC_CTRL_ADDR, 8'h00);
        rchk(`RTC_FLAGS_ADDR, 8'h00);
        vcc_ok <= 1'h1;
        cyc(2);
        rchk(`RTC_CTRL_ADDR, 8'h5B);
        rchk(`RTC_FLAGS_ADDR, 8'h48);
        // ----------------------------------------
        // square wave and calibration clock
        // ----------------------------------------
        fire(1);
        for (int s = 0; s < 4; s++) begin
            wr(`RTC_CTRL_ADDR, 8'h58 | 8'(s));
            freq(exp_tog[s]);
        end
        rchk(`RTC_FLAGS_ADDR, 8'h48);
        wr(`RTC_FLAGS_ADDR, 8'h02);
        wr(`RTC_FLAGS_ADDR, 8'h06);
        wr(`RTC_FLAGS_ADDR, 8'h04);
        freq(16);
        wr(`RTC_FLAGS_ADDR, 8'h00);
        rchk(`RTC_FLAGS_ADDR, 8'h04);
        osc_stopped <= 1'h1;
        do_reset();
        rchk(`RTC_FLAGS_ADDR, 8'h10);
        rchk(`RTC_CTRL_ADDR, 8'h08);
        tz();
        end_of_test();
    end

    // a hang costs one mismatch and ends the run the normal way
    initial begin
        cyc(40000);
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
